// >>> src/iptl_pkg.sv
package iptl_pkg;

  localparam int unsigned NUM_LEVELS      = 32;
  localparam int unsigned NUM_VECTORS     = 256;
  localparam logic [4:0]  MAX_LEVEL       = 5'h1F;
  localparam logic [4:0]  ZERO_LEVEL      = 5'h00;
  localparam logic [7:0]  NMI_VECTOR      = 8'hF8;
  localparam logic [7:0]  RSV_LO_FIRST    = 8'hF4;
  localparam logic [7:0]  RSV_LO_LAST     = 8'hF7;
  localparam logic [7:0]  RSV_HI_FIRST    = 8'hF9;
  localparam logic [7:0]  RSV_HI_LAST     = 8'hFB;
  localparam logic [31:0] PEND_AREA_BYTES = 32'h0000_0024;
  localparam logic [31:0] PEND_VEC_OFFSET = 32'h0000_0004;
  localparam logic [31:0] TABLE_BYTES     = 32'h0000_0404;
  localparam logic [31:0] VEC_BASE_INDEX  = 32'h0000_0008;
  localparam logic [31:0] NMI_IRAM_ADDR   = 32'h0000_0000;
  localparam logic [1:0]  ENTRY_NORMAL    = 2'h0;
  localparam logic [1:0]  ENTRY_LOCKED    = 2'h2;
  localparam logic [31:0] BASE_PTR_ADDR   = 32'h0000_0010;
  localparam logic [31:0] ADDR_ALIGN_MASK = 32'hFFFF_FFFC;

  // Register port map
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_SWPOST      = 4'h2;
  localparam logic [3:0]  REG_HWPEND_LO   = 4'h3;
  localparam logic [3:0]  REG_TBL_BASE    = 4'h4;
  localparam logic [3:0]  REG_HANDLER     = 4'h5;
  localparam logic [3:0]  REG_NMI_VEC     = 4'h6;
  localparam logic [3:0]  REG_RETURN      = 4'h7;
  localparam logic [3:0]  REG_SW_PRIO     = 4'h8;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } iptl_mem_req_s;

  typedef struct packed {
    logic        take;
    logic        is_nmi;
    logic [7:0]  vector;
    logic [31:0] handler;
    logic        locked_fetch;
    logic        bad_type;
  } iptl_dispatch_s;

  typedef enum logic [3:0] {
    ST_INIT_PTR, ST_INIT_NMI, ST_IDLE, ST_POST_RDP, ST_POST_RDV, ST_POST_WRV,
    ST_POST_WRP, ST_SCAN_RDV, ST_FETCH_VEC, ST_DISPATCH
  } iptl_state_e;

endpackage

// >>> src/iptl_prio_enc.sv
`timescale 1ns/1ps
module iptl_prio_enc
  import iptl_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned IDXW  = 5
)
(
  input  wire logic [WIDTH-1:0] bits,
  output logic                  any,
  output logic [IDXW-1:0]       index
);

  // Highest set bit wins: largest vector or level first
  always_comb
  begin
    any   = 1'b0;
    index = '0;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (bits[i])
      begin
        any   = 1'b1;
        index = IDXW'(i);
      end
    end
  end

endmodule

// >>> src/iptl_sync2.sv
`timescale 1ns/1ps
module iptl_sync2
  import iptl_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// >>> src/iptl_core.sv
`timescale 1ns/1ps
module iptl_core
  import iptl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [7:0]  ext_irq_port,
  input  wire logic        nmi_req_n,
  input  wire logic        dma_irq,
  input  wire logic [7:0]  dma_vector,
  output iptl_mem_req_s    mem_req,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output iptl_dispatch_s   dispatch,
  output logic             on_irq_stack,
  output logic             supervisor
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops
  logic [7:0] ext_s;
  logic       nmi_s;

  iptl_sync2 #(.WIDTH(8)) u_sync_port
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .d       (ext_irq_port),
    .q       (ext_s)
  );

  iptl_sync2 #(.WIDTH(1)) u_sync_nmi
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .d       (~nmi_req_n),
    .q       (nmi_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  iptl_state_e  state_r;
  logic [31:0]  tbl_base_r;
  logic [31:0]  nmi_vec_r;
  logic [4:0]   cur_prio_r;
  logic         in_nmi_r;
  logic [255:0] hw_pending_register;
  logic [7:0]   ext_prev_r;
  logic         nmi_prev_r;
  logic         nmi_pend_r;
  logic         sw_post_pend_r;
  logic [7:0]   sw_post_vec_r;
  logic [31:0]  tmp_prio_r;
  logic [31:0]  tmp_vec_r;
  logic [4:0]   sw_prio_r;
  logic         sw_valid_r;
  logic [7:0]   sel_vec_r;
  logic [31:0]  process_controls_reg;
  logic [4:0]   save_prio_r [0:7];
  logic         save_nmi_r  [0:7];
  logic [2:0]   depth_r;
  logic         ret_req;
  logic         irq_rd_r;

  // Process controls: bit 1 supervisor, bits 20:16 priority
  localparam int unsigned PCR_SUP = 1;
  localparam int unsigned PCR_PRI = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware request resolution
  logic       hw_any;
  logic [7:0] hw_vec;
  logic [4:0] hw_prio;

  iptl_prio_enc #(.WIDTH(256), .IDXW(8)) u_hw_enc
  (
    .bits  (hw_pending_register),
    .any   (hw_any),
    .index (hw_vec)
  );

  assign hw_prio = hw_vec[7:3];

  function automatic logic vec_usable(input logic [7:0] v);
    vec_usable = (v[7:3] != ZERO_LEVEL)
      && !(v >= RSV_LO_FIRST && v <= RSV_LO_LAST)
      && !(v >= RSV_HI_FIRST && v <= RSV_HI_LAST) && (v != NMI_VECTOR);
  endfunction

  // Strict compare, with level 31 allowed to preempt level 31.
  // No decision while a take pulse stands: level and pending bit update at its end.
  function automatic logic beats(input logic [4:0] p);
    beats = !in_nmi_r && !dispatch.take && (p != ZERO_LEVEL)
      && ((p > cur_prio_r) || (p == MAX_LEVEL));
  endfunction

  logic nmi_edge;
  assign nmi_edge = nmi_s && !nmi_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Table-side scan: level first, then vector within that level's byte
  logic       tp_any;
  logic [4:0] tp_lvl;
  logic       tv_any;
  logic [2:0] tv_bit;

  iptl_prio_enc #(.WIDTH(32), .IDXW(5)) u_tp_enc
  (
    .bits  (tmp_prio_r),
    .any   (tp_any),
    .index (tp_lvl)
  );

  iptl_prio_enc #(.WIDTH(8), .IDXW(3)) u_tv_enc
  (
    .bits  (tmp_vec_r[8*tp_lvl[1:0] +: 8]),
    .any   (tv_any),
    .index (tv_bit)
  );

  logic [31:0] vec_word_addr;
  assign vec_word_addr = (tbl_base_r + PEND_VEC_OFFSET + {25'h0, tp_lvl[4:2], 2'h0})
                         & ADDR_ALIGN_MASK;

  function automatic logic [31:0] entry_addr(input logic [7:0] v);
    entry_addr = tbl_base_r + PEND_AREA_BYTES
               + ({22'h0, v, 2'h0} - {VEC_BASE_INDEX[29:0], 2'h0});
  endfunction

  // Posting byte: vector/8 lands in word 1 + vector/32 at byte vector/8 mod 4
  logic [31:0] post_word_addr;
  assign post_word_addr = tbl_base_r + PEND_VEC_OFFSET
                        + {24'h0, sw_post_vec_r[7:5], 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Dispatch decision
  logic take_hw;
  logic take_sw;
  logic take_nmi;
  assign take_nmi = nmi_pend_r && !in_nmi_r;
  assign take_hw  = hw_any && beats(hw_prio) && (!sw_valid_r || hw_prio >= sw_prio_r);
  assign take_sw  = sw_valid_r && beats(sw_prio_r) && !take_hw;
  assign ret_req  = reg_wr && reg_addr == REG_RETURN && depth_r != 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r       <= ST_INIT_PTR;
      tbl_base_r    <= '0;
      nmi_vec_r     <= '0;
      mem_req       <= '0;
      tmp_prio_r    <= '0;
      tmp_vec_r     <= '0;
      sel_vec_r     <= '0;
      dispatch      <= '0;
      sw_prio_r     <= '0;
      sw_valid_r    <= 1'b0;
    end
    else if (ce)
    begin
      dispatch.take <= 1'b0;
      unique case (state_r)
        ST_INIT_PTR:
        begin
          mem_req <= '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: BASE_PTR_ADDR, wdata: '0};
          if (mem_req.req && mem_ack)
          begin
            tbl_base_r <= mem_rdata & ADDR_ALIGN_MASK;
            mem_req    <= '0;
            state_r    <= ST_INIT_NMI;
          end
        end
        ST_INIT_NMI:
        begin
          mem_req <= '{req: 1'b1, we: 1'b0, lock: 1'b0,
                       addr: entry_addr(NMI_VECTOR), wdata: '0};
          if (mem_req.req && mem_ack)
          begin
            nmi_vec_r <= mem_rdata;
            mem_req   <= '0;
            state_r   <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (take_nmi)
          begin
            sel_vec_r <= NMI_VECTOR;
            state_r   <= ST_DISPATCH;
          end
          else if (sw_post_pend_r)
          begin
            mem_req <= '{req: 1'b1, we: 1'b0, lock: 1'b1, addr: tbl_base_r, wdata: '0};
            state_r <= ST_POST_RDP;
          end
          else if (take_hw)
          begin
            sel_vec_r <= hw_vec;
            mem_req   <= '{req: 1'b1, we: 1'b0, lock: 1'b0,
                           addr: entry_addr(hw_vec), wdata: '0};
            state_r   <= ST_FETCH_VEC;
          end
          else if (take_sw)
          begin
            // The stored priority is spent by one scan; software rewrites it to rescan
            mem_req    <= '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: tbl_base_r, wdata: '0};
            sw_valid_r <= 1'b0;
            state_r    <= ST_SCAN_RDV;
          end
        end
        ST_POST_RDP:
        begin
          if (mem_ack)
          begin
            tmp_prio_r <= mem_rdata | (32'h1 << sw_post_vec_r[7:3]);
            mem_req    <= '{req: 1'b1, we: 1'b0, lock: 1'b1, addr: post_word_addr, wdata: '0};
            state_r    <= ST_POST_RDV;
          end
        end
        ST_POST_RDV:
        begin
          if (mem_ack)
          begin
            mem_req <= '{req: 1'b1, we: 1'b1, lock: 1'b1, addr: post_word_addr,
                         wdata: mem_rdata | (32'h1 << sw_post_vec_r[4:0])};
            state_r <= ST_POST_WRV;
          end
        end
        ST_POST_WRV:
        begin
          if (mem_ack)
          begin
            mem_req <= '{req: 1'b1, we: 1'b1, lock: 1'b1, addr: tbl_base_r,
                         wdata: tmp_prio_r};
            state_r <= ST_POST_WRP;
          end
        end
        ST_POST_WRP:
        begin
          if (mem_ack)
          begin
            mem_req <= '0;
            state_r <= ST_IDLE;
          end
        end
        ST_SCAN_RDV:
        begin
          // Priority word first, then the bitmap word of the top pending level.
          // Reads only, so no lock: the lock belongs to posting alone.
          if (mem_req.req && mem_ack)
          begin
            mem_req <= '0;
            if (mem_req.addr == tbl_base_r)
              tmp_prio_r <= mem_rdata;
            else
            begin
              tmp_vec_r <= mem_rdata;
              state_r   <= ST_FETCH_VEC;
            end
          end
          else if (!mem_req.req && tp_any)
            mem_req <= '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: vec_word_addr, wdata: '0};
          else if (!mem_req.req)
            state_r <= ST_IDLE;
        end
        ST_FETCH_VEC:
        begin
          if (!mem_req.req)
          begin
            sel_vec_r <= {tp_lvl, tv_bit};
            mem_req   <= '{req: 1'b1, we: 1'b0, lock: 1'b0,
                           addr: entry_addr({tp_lvl, tv_bit}), wdata: '0};
          end
          else if (mem_ack)
          begin
            tmp_vec_r <= mem_rdata;
            mem_req   <= '0;
            state_r   <= ST_DISPATCH;
          end
        end
        ST_DISPATCH:
        begin
          dispatch.take         <= 1'b1;
          dispatch.vector       <= sel_vec_r;
          dispatch.is_nmi       <= sel_vec_r == NMI_VECTOR;
          dispatch.handler      <= ((sel_vec_r == NMI_VECTOR) ? nmi_vec_r : tmp_vec_r)
                                   & ADDR_ALIGN_MASK;
          dispatch.locked_fetch <= (((sel_vec_r == NMI_VECTOR) ? nmi_vec_r[1:0]
                                    : tmp_vec_r[1:0]) == ENTRY_LOCKED);
          dispatch.bad_type     <= !(((sel_vec_r == NMI_VECTOR) ? nmi_vec_r[1:0]
                                    : tmp_vec_r[1:0]) inside {ENTRY_NORMAL, ENTRY_LOCKED});
          state_r               <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
      if (reg_wr && reg_addr == REG_SW_PRIO)
      begin
        sw_prio_r  <= reg_wdata[4:0];
        sw_valid_r <= reg_wdata[4:0] != ZERO_LEVEL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal pending register for hardware sources
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hw_pending_register <= '0;
      ext_prev_r          <= '0;
    end
    else if (ce)
    begin
      ext_prev_r <= ext_s;
      for (int i = 0; i < 8; i++)
      begin
        // Port pin i posts vector 8*(i+1)+7; edges set, dispatch clears, set wins
        if (ext_s[i] && !ext_prev_r[i])
          hw_pending_register[8*(i+1)+7] <= 1'b1;
      end
      if (dispatch.take && !dispatch.is_nmi)
        hw_pending_register[dispatch.vector] <= 1'b0;
      if (dma_irq && vec_usable(dma_vector))
        hw_pending_register[dma_vector] <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        if (ext_s[i] && !ext_prev_r[i] && dispatch.take
            && dispatch.vector == 8'(8*(i+1)+7))
          hw_pending_register[8*(i+1)+7] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // NMI edge and software post request
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // Matches the idle level after inversion, so reset makes no false edge
      nmi_prev_r     <= 1'b0;
      nmi_pend_r     <= 1'b0;
      sw_post_pend_r <= 1'b0;
      sw_post_vec_r  <= '0;
    end
    else if (ce)
    begin
      nmi_prev_r <= nmi_s;
      if (nmi_edge)
        nmi_pend_r <= 1'b1;
      else if (state_r == ST_IDLE && take_nmi)
        nmi_pend_r <= 1'b0;
      if (reg_wr && reg_addr == REG_SWPOST && vec_usable(reg_wdata[7:0]))
      begin
        sw_post_pend_r <= 1'b1;
        sw_post_vec_r  <= reg_wdata[7:0];
      end
      else if (state_r == ST_POST_WRP && mem_ack)
        sw_post_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Context save and restore
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_prio_r           <= '0;
      in_nmi_r             <= 1'b0;
      depth_r              <= '0;
      process_controls_reg <= '0;
      on_irq_stack         <= 1'b0;
      supervisor           <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        save_prio_r[i] <= '0;
        save_nmi_r[i]  <= 1'b0;
      end
    end
    else if (ce)
    begin
      if (dispatch.take)
      begin
        save_prio_r[depth_r] <= cur_prio_r;
        save_nmi_r[depth_r]  <= in_nmi_r;
        depth_r              <= depth_r + 3'h1;
        cur_prio_r           <= dispatch.vector[7:3];
        in_nmi_r             <= dispatch.is_nmi;
        on_irq_stack         <= 1'b1;
        supervisor           <= 1'b1;
        process_controls_reg[PCR_SUP] <= 1'b1;
        process_controls_reg[PCR_PRI +: 5] <= dispatch.vector[7:3];
      end
      else if (ret_req)
      begin
        cur_prio_r   <= save_prio_r[depth_r - 3'h1];
        in_nmi_r     <= save_nmi_r[depth_r - 3'h1];
        depth_r      <= depth_r - 3'h1;
        on_irq_stack <= depth_r != 3'h1;
        process_controls_reg[PCR_PRI +: 5] <= save_prio_r[depth_r - 3'h1];
      end
      else if (reg_wr && reg_addr == REG_CTRL)
      begin
        cur_prio_r           <= reg_wdata[PCR_PRI +: 5];
        supervisor           <= reg_wdata[PCR_SUP];
        process_controls_reg <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (ce)
    begin
      if (reg_rd)
      begin
        unique case (reg_addr)
          REG_CTRL:      reg_rdata <= process_controls_reg;
          REG_STATUS:    reg_rdata <= {22'h0, in_nmi_r, sw_post_pend_r, nmi_pend_r,
                                       hw_any, 1'b0, state_r == ST_IDLE, depth_r,
                                       1'b0};
          REG_SWPOST:    reg_rdata <= {24'h0, sw_post_vec_r};
          REG_HWPEND_LO: reg_rdata <= {23'h0, hw_any, hw_vec};
          REG_TBL_BASE:  reg_rdata <= tbl_base_r;
          REG_HANDLER:   reg_rdata <= dispatch.handler;
          REG_NMI_VEC:   reg_rdata <= nmi_vec_r;
          REG_SW_PRIO:   reg_rdata <= {26'h0, sw_valid_r, sw_prio_r};
          default:       reg_rdata <= '0;
        endcase
      end
      else
        reg_rdata <= '0;
    end
  end

endmodule

// >>> dv/iptl_mem_model.sv
`timescale 1ns/1ps
module iptl_mem_model
  import iptl_pkg::*;
#(
  parameter logic [31:0] TBASE = 32'h0000_1000
)
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire iptl_mem_req_s mem_req,
  output logic               mem_ack,
  output logic        [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  int          wait_r;
  // Untouched words: pending area clear, entries of type 00 or 10 only
  function automatic logic [31:0] peek(input logic [31:0] a);
    if (mem.exists(a))
      return mem[a];
    if (a == BASE_PTR_ADDR)
      return TBASE;
    if (a < TBASE + PEND_AREA_BYTES)
      return 32'h0;
    return {8'hA5, a[21:0], a[2], 1'b0};
  endfunction
  ////////////////////////////////////////
  // Random answer latency; data toggles while no answer is given
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r    <= 0;
    end
    else if (!mem_ack && mem_req.req && wait_r == 0)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= peek(mem_req.addr);
      if (mem_req.we)
        mem[mem_req.addr] = mem_req.wdata;
      wait_r    <= $urandom_range(3, 0);
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack)
        wait_r <= wait_r - 1;
    end
  end
endmodule

// >>> dv/iptl_core_asserts.sv
`timescale 1ns/1ps
module iptl_core_asserts
  import iptl_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           ce,
  input wire logic [3:0]     reg_addr,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [31:0]    reg_rdata,
  input wire iptl_mem_req_s  mem_req,
  input wire logic           mem_ack,
  input wire iptl_dispatch_s dispatch,
  input wire logic           on_irq_stack,
  input wire logic           supervisor
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic in_nmi_r;
  // Nothing may be taken between an NMI take and its return write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      in_nmi_r <= 1'b0;
    else if (ce && dispatch.take && dispatch.is_nmi)
      in_nmi_r <= 1'b1;
    else if (ce && reg_wr && reg_addr == REG_RETURN)
      in_nmi_r <= 1'b0;
  end
  sequence s_enter;
    ##[0:1] (supervisor && on_irq_stack);
  endsequence
  ////////////////////////////////////////
  a_take_pulse: assert property (dispatch.take |=> !dispatch.take)
    else $error("take longer than one cycle");
  a_enter_mode: assert property (dispatch.take |-> s_enter)
    else $error("handler entered without supervisor and interrupt stack");
  a_no_level0: assert property (dispatch.take |-> dispatch.vector[7:3] != ZERO_LEVEL)
    else $error("level zero vector taken");
  a_no_reserved: assert property (dispatch.take |-> !(dispatch.vector inside
    {[RSV_LO_FIRST:RSV_LO_LAST], [RSV_HI_FIRST:RSV_HI_LAST]}))
    else $error("reserved vector taken");
  a_nmi_code: assert property (dispatch.take |->
    dispatch.is_nmi == (dispatch.vector == NMI_VECTOR))
    else $error("nmi flag and vector disagree");
  a_nmi_alone: assert property (dispatch.take |-> !in_nmi_r)
    else $error("take during nmi handler");
  a_req_hold: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req))
    else $error("memory request changed before answer");
  a_lock_first: assert property ($rose(mem_req.lock) |-> mem_req.req && !mem_req.we)
    else $error("lock did not open with a read");
  a_lock_last: assert property ($fell(mem_req.lock) |-> $past(mem_req.we) && $past(mem_ack))
    else $error("lock dropped before write back");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
endmodule
bind iptl_core iptl_core_asserts u_chk (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .mem_req, .mem_ack, .dispatch, .on_irq_stack, .supervisor);

// >>> dv/iptl_core_test.sv
`timescale 1ns/1ps
module iptl_core_test
  import iptl_pkg::*;
;
  localparam logic [31:0] TBASE = 32'h0000_1000;
  logic           sys_clk = 1'b0;
  logic           rst, reg_wr, reg_rd, nmi_req_n, dma_irq, mem_ack, on_irq_stack, supervisor;
  logic           rd_d = 1'b0;
  logic [3:0]     reg_addr;
  logic [7:0]     ext_irq_port, dma_vector;
  logic [31:0]    reg_wdata, reg_rdata, mem_rdata, na;
  logic [63:0]    rd_q[$], re;
  logic [42:0]    tk_q[$], te;
  iptl_mem_req_s  mem_req;
  iptl_dispatch_s dispatch;
  int             err_total, checked;
  always #50 sys_clk = ~sys_clk;
  iptl_core dut (.sys_clk, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_port, .nmi_req_n, .dma_irq, .dma_vector, .mem_req, .mem_ack,
    .mem_rdata, .dispatch, .on_irq_stack, .supervisor);
  iptl_mem_model #(.TBASE(TBASE)) mdl (.sys_clk, .rst, .mem_req, .mem_ack, .mem_rdata);
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [42:0] seen, input logic [42:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] eadr(input logic [7:0] v);
    return TBASE + PEND_AREA_BYTES + {22'h0, v - 8'h08, 2'h0};
  endfunction
  function automatic logic [42:0] ent(input logic [7:0] v);
    logic [31:0] a;
    a = eadr(v);
    return {v == NMI_VECTOR, a[2], 1'b0, v, 8'hA5, a[21:0], 2'h0};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rd_q.push_back({m, x});
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic dma(input logic [7:0] v);
    @(posedge sys_clk);
    dma_irq    <= 1'b1;
    dma_vector <= v;
    @(posedge sys_clk);
    dma_irq    <= 1'b0;
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && tk_q.size() > 0; i++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  // Return write with random data; the next take is expected after it
  task automatic nxt(input logic [7:0] v);
    tk_q.push_back(ent(v));
    wr(REG_RETURN, $urandom());
    drain();
  endtask
  ////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d && rd_q.size() > 0)
    begin
      re = rd_q.pop_front();
      check("rdata", {11'h0, reg_rdata & re[63:32]}, {11'h0, re[31:0]});
    end
    if (dispatch.take === 1'b1)
    begin
      te = (tk_q.size() > 0) ? tk_q.pop_front() : '1;
      check("take", {dispatch.is_nmi, dispatch.locked_fetch, dispatch.bad_type,
        dispatch.vector, dispatch.handler}, te);
    end
  end
  initial
  begin
    #2_000_000;
    err_total++;
    close_out();
  end
  initial
  begin
    rst          = 1'b1;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 32'h0;
    ext_irq_port = 8'h00;
    nmi_req_n    = 1'b1;
    dma_irq      = 1'b0;
    dma_vector   = 8'h00;
    na           = eadr(NMI_VECTOR);
    void'($urandom(80));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rd(REG_TBL_BASE, 32'hFFFF_FFFF, TBASE);
    rd(REG_NMI_VEC, 32'hFFFF_FFFC, {8'hA5, na[21:0], 2'h0});
    rd(4'hF, 32'hFFFF_FFFF, 32'h0);
    tk_q.push_back(ent(8'h1F));
    ext_irq_port[2] <= 1'b1;
    drain();
    rd(REG_CTRL, 32'h001F_0002, 32'h0003_0002);
    ext_irq_port[0] <= 1'b1;
    dma(8'h19);
    dma(8'h1C);
    repeat (40) @(posedge sys_clk);
    nxt(8'h1C);
    nxt(8'h19);
    nxt(8'h0F);
    wr(REG_RETURN, 32'h0);
    tk_q.push_back(ent(8'hFC));
    dma(8'hFC);
    drain();
    tk_q.push_back(ent(8'hFD));
    dma(8'hFD);
    drain();
    tk_q.push_back(ent(NMI_VECTOR));
    nmi_req_n <= 1'b0;
    drain();
    dma(8'hFE);
    wr(REG_SWPOST, 32'h0000_0005);
    wr(REG_SWPOST, 32'h0000_00F5);
    wr(REG_SWPOST, 32'h0000_0050);
    repeat (40) @(posedge sys_clk);
    check("prio", {11'h0, mdl.peek(TBASE)}, 43'h0_0000_0400);
    check("vecs", {11'h0, mdl.peek(TBASE + 32'h0000_000C)}, 43'h0_0001_0000);
    nmi_req_n <= 1'b1;
    nxt(8'hFE);
    wr(REG_RETURN, 32'h0);
    wr(REG_RETURN, 32'h0);
    // Outside agent posts vector 0x48 one level lower: bitmap bit, then priority bit
    mdl.mem[TBASE + 32'h0000_000C] = mdl.peek(TBASE + 32'h0000_000C) | 32'h0000_0100;
    mdl.mem[TBASE] = mdl.peek(TBASE) | 32'h0000_0200;
    wr(REG_SW_PRIO, 32'h0000_000A);
    nxt(8'h50);
    wr(REG_RETURN, 32'h0);
    rd(REG_CTRL, 32'h001F_0000, 32'h0);
    check("stack", {42'h0, on_irq_stack}, 43'h0);
    repeat (2) @(posedge sys_clk);
    check("left", {11'h0, 32'(tk_q.size())}, 43'h0);
    close_out();
  end
endmodule
